// *** srp_defs.svh ***
// constants for the serial remote command parser: header fields,
// local command codes, status bits, reset values and table geometry.
// assumes it is included once per compile unit by its bare name.
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ============================================================
// header fields
`define SRP_TYPE_DATA   2'b01
`define SRP_TYPE_RPC    2'b10
`define SRP_TYPE_LOCAL  2'b11
`define SRP_BIT_WRITE   5
`define SRP_BIT_STORED  4
`define SRP_BIT_INC     3
`define SRP_BIT_ADDR    2

// ============================================================
// local read codes
`define SRP_C_UADDR     8'hc0
`define SRP_C_STAT      8'hc1
`define SRP_C_CRCEN     8'hc2
`define SRP_C_CRCCNT    8'hc3
`define SRP_C_TBLFLAG   8'hca
`define SRP_C_TMO       8'hcb
`define SRP_C_NAME0     8'hd0
`define SRP_C_NAME1     8'hd1
`define SRP_C_NAME2     8'hd2
`define SRP_C_NAME3     8'hd3
`define SRP_C_CFG0      8'hd5
`define SRP_C_CFG1      8'hd6
`define SRP_C_CFG2      8'hd7
`define SRP_C_ADDRL     8'hd8
`define SRP_C_ADDRH     8'hd9
`define SRP_C_VER       8'hda
`define SRP_C_UID       8'hdb
`define SRP_C_PITCH     8'hdc
`define SRP_C_SIZEL     8'hdd
`define SRP_C_SIZEH     8'hde
`define SRP_C_COOKIE    8'hdf

// ============================================================
// local write codes
`define SRP_W_STAT      8'he1
`define SRP_W_CRCEN     8'he2
`define SRP_W_CRCCNT    8'he3
`define SRP_W_TBLFLAG   8'hea
`define SRP_W_TMO       8'heb
`define SRP_W_LED       8'hf7
`define SRP_W_ADDRL     8'hf8
`define SRP_W_ADDRH     8'hf9
`define SRP_W_ADDADD    8'hfa
`define SRP_W_UID       8'hfd
`define SRP_W_PRST      8'hfe
`define SRP_W_PARSER    8'hff

// ============================================================
// status bits and values
`define SRP_ST_TMO      6
`define SRP_ST_WPROT    5
`define SRP_ST_OVF      4
`define SRP_ST_WDOG     3
`define SRP_ST_CRC      0
`define SRP_ST_MASK     8'h79
`define SRP_COOKIE      8'h5a
`define SRP_PRST_KEY    8'h5a
`define SRP_CRC_POLY    8'h8c
`define SRP_TMO_RESET   8'hff
`define SRP_VERSION     8'h01
`define SRP_UADDR       8'h00
`define SRP_UID_RESET   8'h00
// name characters: arbitrary values
`define SRP_CARD_NAME   32'h4e4f4445
`define SRP_CFG_NAME    24'h434647

// ============================================================
// memory geometry
`define SRP_PITCH       8'h08
`define SRP_PITCH_SHIFT 3
`define SRP_TBL_SIZE    16'h0200
`define SRP_DMEM_SIZE   16'h0100

`endif

// *** srp_pkg.sv ***
// types for the serial remote command parser.
// assumes nothing beyond a systemverilog compile unit.
package srp_pkg;

  // ============================================================
  // parser states, gray coded along header-address-data-crc-answer
  typedef enum logic [3:0] {
    SRP_IDLE    = 4'h0,
    SRP_ADDR_LO = 4'h1,
    SRP_ADDR_HI = 4'h3,
    SRP_XFER    = 4'h2,
    SRP_CRC     = 4'h6,
    SRP_RESP    = 4'h7,
    SRP_LWRITE  = 4'h4,
    SRP_FETCH   = 4'hc,
    SRP_DISCARD = 4'hd
  } srp_state_t;

endpackage

// *** srp_parser.sv ***
// remote side command interpreter for a byte serial register protocol.
// assumes a uart on the same clock delivering bytes and tenth-character ticks.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.svh"

module srp_parser (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // received characters, same clock domain
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // tenth of a character time tick and watchdog event
  input  wire logic       tenth_tick,
  input  wire logic       wdog_bite,
  // response characters
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic [7:0]      tx_data,
  // side outputs
  output logic [7:0]      led_out,
  output logic [7:0]      unit_id_out,
  output logic            proc_reset,
  output logic [7:0]      error_status
);

  // ============================================================
  // state
  srp_pkg::srp_state_t state_q;       // parser state
  logic [7:0]  hdr_q;                 // current data or local header
  logic [7:0]  lo_q;                  // address low byte
  logic [7:0]  resp_q;                // pending local read answer
  logic        lrd_q;                 // local read answer pending
  logic [3:0]  len_q;                 // bytes minus one
  logic [3:0]  off_q;                 // byte offset in transfer
  logic [15:0] ptr_q;                 // address pointer
  logic [8:0]  rpc_ptr_q;             // list fetch pointer
  logic        in_rpc_q;              // running a stored list
  logic [7:0]  pend_q;                // byte held while busy
  logic        pend_v_q;
  logic [7:0]  head_q;                // buffer output entry
  logic        head_v_q;
  logic [7:0]  spare_q;               // buffer second entry
  logic        spare_v_q;
  logic [7:0]  stat_q;                // error status
  logic [7:0]  crc_in_q;              // crc over received bytes
  logic [7:0]  crc_out_q;             // crc over answer bytes
  logic [7:0]  cerr_q;                // crc error count
  logic        crc_en_q;              // crc checking enabled
  logic        tbl_q;                 // table access flag
  logic [7:0]  timeout_q;             // gap limit in tenths
  logic [8:0]  gap_q;                 // tenths since last byte; one bit wider so a 25.5 limit can trip
  logic [7:0]  led_q;
  logic [7:0]  uid_q;
  logic        prst_q;                // processor reset pulse
  logic [7:0]  dmem [0:255];          // data space
  logic [7:0]  tmem [0:511];          // stored list table

  // ============================================================
  // helpers
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `SRP_CRC_POLY) : (r >> 1);
    crc8 = r;
  endfunction

  // size code to byte count minus one: 0,1,3,7
  function automatic logic [3:0] len_of(input logic [1:0] code);
    len_of = 4'((4'h1 << code) - 4'h1);
  endfunction

  // codes that do something; the rest are reserved
  function automatic logic rsvd(input logic [7:0] b);
    case (b)
      `SRP_C_UADDR, `SRP_C_STAT, `SRP_C_CRCEN, `SRP_C_CRCCNT,
      `SRP_C_TBLFLAG, `SRP_C_TMO, `SRP_C_NAME0, `SRP_C_NAME1,
      `SRP_C_NAME2, `SRP_C_NAME3, `SRP_C_CFG0, `SRP_C_CFG1,
      `SRP_C_CFG2, `SRP_C_ADDRL, `SRP_C_ADDRH, `SRP_C_VER,
      `SRP_C_UID, `SRP_C_PITCH, `SRP_C_SIZEL, `SRP_C_SIZEH,
      `SRP_C_COOKIE, `SRP_W_STAT, `SRP_W_CRCEN, `SRP_W_CRCCNT,
      `SRP_W_TBLFLAG, `SRP_W_TMO, `SRP_W_LED, `SRP_W_ADDRL,
      `SRP_W_ADDRH, `SRP_W_ADDADD, `SRP_W_UID, `SRP_W_PRST,
      `SRP_W_PARSER: rsvd = 1'b0;
      default:       rsvd = 1'b1;
    endcase
  endfunction

  // ============================================================
  // byte sourcing and decode
  logic        wr;                    // current data command writes
  logic        from_tbl;              // next byte comes from the table
  logic        rx_wants;              // state consumes a stream byte
  logic        in_v;
  logic [7:0]  in_b;
  logic        take;                  // stream byte consumed
  logic        byte_ok;
  logic [7:0]  byte_b;
  logic [7:0]  tbl_b;
  logic        push_ready;
  logic        push_v;
  logic [7:0]  push_b;
  logic        xfer_step;
  logic        xfer_last;
  logic [15:0] acc_addr;
  logic        in_space;
  logic [7:0]  rd_byte;
  logic        wr_strobe;
  logic        tmo;
  logic        crc_bad;
  logic [7:0]  lrd_val;

  assign wr = hdr_q[`SRP_BIT_WRITE];
  assign tbl_b = tmem[rpc_ptr_q];

  // inside a list, addresses always and stored data come from the table
  always_comb
  begin
    from_tbl = 1'b0;
    if (in_rpc_q)
    begin
      if (state_q == srp_pkg::SRP_ADDR_LO || state_q == srp_pkg::SRP_ADDR_HI)
        from_tbl = 1'b1;
      else if (state_q == srp_pkg::SRP_XFER && wr && hdr_q[`SRP_BIT_STORED])
        from_tbl = 1'b1;
    end
  end

  // which states wait for a stream byte
  always_comb
  begin
    case (state_q)
      srp_pkg::SRP_IDLE, srp_pkg::SRP_CRC, srp_pkg::SRP_LWRITE,
      srp_pkg::SRP_DISCARD:  rx_wants = 1'b1;
      srp_pkg::SRP_ADDR_LO,
      srp_pkg::SRP_ADDR_HI:  rx_wants = !from_tbl;
      srp_pkg::SRP_XFER:     rx_wants = wr && !from_tbl;
      default:               rx_wants = 1'b0;
    endcase
  end

  assign in_v    = pend_v_q | rx_valid;
  assign in_b    = pend_v_q ? pend_q : rx_data;
  assign take    = in_v & rx_wants;
  assign byte_ok = from_tbl | take;
  assign byte_b  = from_tbl ? tbl_b : in_b;

  // successive bytes from the pointer, in whichever space is selected
  assign acc_addr = ptr_q + {12'h000, off_q};
  assign in_space = tbl_q ? (acc_addr < `SRP_TBL_SIZE) : (acc_addr < `SRP_DMEM_SIZE);
  assign rd_byte  = !in_space ? 8'h00 : (tbl_q ? tmem[acc_addr[8:0]] : dmem[acc_addr[7:0]]);

  assign push_ready = !spare_v_q;
  assign xfer_step  = (state_q == srp_pkg::SRP_XFER) && (wr ? byte_ok : push_ready);
  assign xfer_last  = xfer_step && (off_q == len_q);
  assign wr_strobe  = xfer_step && wr;
  assign push_v     = push_ready && ((state_q == srp_pkg::SRP_RESP) || (state_q == srp_pkg::SRP_XFER && !wr));
  assign push_b     = (state_q == srp_pkg::SRP_RESP) ? (lrd_q ? resp_q : crc_out_q) : rd_byte;

  // gap check only while idle-waiting for the stream; a stalled answer never times out
  assign tmo = rx_wants && !in_v && (gap_q > {1'b0, timeout_q});

  // residue of the one-wire crc over frame plus its crc byte is zero
  assign crc_bad = (state_q == srp_pkg::SRP_CRC) && take && crc_en_q && (crc8(crc_in_q, in_b) != 8'h00);

  // local read answers
  always_comb
  begin
    case (in_b)
      `SRP_C_UADDR:   lrd_val = `SRP_UADDR;
      `SRP_C_STAT:    lrd_val = stat_q;
      `SRP_C_CRCEN:   lrd_val = {7'h00, crc_en_q};
      `SRP_C_CRCCNT:  lrd_val = cerr_q;
      `SRP_C_TBLFLAG: lrd_val = {7'h00, tbl_q};
      `SRP_C_TMO:     lrd_val = timeout_q;
      `SRP_C_NAME0:   lrd_val = 8'(`SRP_CARD_NAME >> 24);
      `SRP_C_NAME1:   lrd_val = 8'(`SRP_CARD_NAME >> 16);
      `SRP_C_NAME2:   lrd_val = 8'(`SRP_CARD_NAME >> 8);
      `SRP_C_NAME3:   lrd_val = 8'(`SRP_CARD_NAME);
      `SRP_C_CFG0:    lrd_val = 8'(`SRP_CFG_NAME >> 16);
      `SRP_C_CFG1:    lrd_val = 8'(`SRP_CFG_NAME >> 8);
      `SRP_C_CFG2:    lrd_val = 8'(`SRP_CFG_NAME);
      `SRP_C_ADDRL:   lrd_val = ptr_q[7:0];
      `SRP_C_ADDRH:   lrd_val = ptr_q[15:8];
      `SRP_C_VER:     lrd_val = `SRP_VERSION;
      `SRP_C_UID:     lrd_val = uid_q;
      `SRP_C_PITCH:   lrd_val = `SRP_PITCH;
      `SRP_C_SIZEL:   lrd_val = 8'(`SRP_TBL_SIZE);
      `SRP_C_SIZEH:   lrd_val = 8'(`SRP_TBL_SIZE >> 8);
      `SRP_C_COOKIE:  lrd_val = `SRP_COOKIE;
      default:        lrd_val = 8'h00;
    endcase
  end

  // ============================================================
  // parser state machine
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= srp_pkg::SRP_IDLE;
      hdr_q     <= 8'h00;
      lo_q      <= 8'h00;
      resp_q    <= 8'h00;
      lrd_q     <= 1'b0;
      len_q     <= 4'h0;
      off_q     <= 4'h0;
      rpc_ptr_q <= 9'h000;
      in_rpc_q  <= 1'b0;
    end
    else if (tmo)
    begin
      // framing reset drops any half command
      state_q  <= srp_pkg::SRP_IDLE;
      in_rpc_q <= 1'b0;
      lrd_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        srp_pkg::SRP_IDLE:
          if (take)
          begin
            lrd_q <= 1'b0;
            if (in_b[7:6] == `SRP_TYPE_DATA)
            begin
              hdr_q   <= in_b;
              off_q   <= 4'h0;
              len_q   <= len_of(in_b[1:0]);
              state_q <= in_b[`SRP_BIT_ADDR] ? srp_pkg::SRP_ADDR_LO : srp_pkg::SRP_XFER;
            end
            else if (in_b[7:6] == `SRP_TYPE_RPC)
            begin
              // lists 0xbb..0xbd are the special procedures, loaded like any list
              in_rpc_q  <= 1'b1;
              rpc_ptr_q <= {in_b[5:0], {`SRP_PITCH_SHIFT{1'b0}}};
              state_q   <= srp_pkg::SRP_FETCH;
            end
            else if (in_b == `SRP_W_PARSER)
              state_q <= srp_pkg::SRP_IDLE;
            else if (in_b[7:6] != `SRP_TYPE_LOCAL || rsvd(in_b))
              state_q <= srp_pkg::SRP_DISCARD;
            else if (!in_b[`SRP_BIT_WRITE])
            begin
              resp_q  <= lrd_val;
              lrd_q   <= 1'b1;
              state_q <= srp_pkg::SRP_CRC;
            end
            else
            begin
              hdr_q   <= in_b;
              state_q <= srp_pkg::SRP_LWRITE;
            end
          end
        srp_pkg::SRP_FETCH:
        begin
          rpc_ptr_q <= rpc_ptr_q + 9'h001;
          if (tbl_b[7:6] == `SRP_TYPE_DATA)
          begin
            hdr_q   <= tbl_b;
            off_q   <= 4'h0;
            len_q   <= len_of(tbl_b[1:0]);
            state_q <= tbl_b[`SRP_BIT_ADDR] ? srp_pkg::SRP_ADDR_LO : srp_pkg::SRP_XFER;
          end
          else
            state_q <= srp_pkg::SRP_CRC;
        end
        srp_pkg::SRP_ADDR_LO:
          if (byte_ok)
          begin
            lo_q      <= byte_b;
            rpc_ptr_q <= from_tbl ? rpc_ptr_q + 9'h001 : rpc_ptr_q;
            state_q   <= srp_pkg::SRP_ADDR_HI;
          end
        srp_pkg::SRP_ADDR_HI:
          if (byte_ok)
          begin
            rpc_ptr_q <= from_tbl ? rpc_ptr_q + 9'h001 : rpc_ptr_q;
            state_q   <= srp_pkg::SRP_XFER;
          end
        srp_pkg::SRP_XFER:
          if (xfer_step)
          begin
            off_q     <= off_q + 4'h1;
            rpc_ptr_q <= from_tbl ? rpc_ptr_q + 9'h001 : rpc_ptr_q;
            if (xfer_last)
              state_q <= in_rpc_q ? srp_pkg::SRP_FETCH : srp_pkg::SRP_CRC;
          end
        srp_pkg::SRP_LWRITE:
          if (take)
            state_q <= srp_pkg::SRP_CRC;
        srp_pkg::SRP_CRC:
          if (take)
            state_q <= srp_pkg::SRP_RESP;
        srp_pkg::SRP_RESP:
          if (push_ready)
          begin
            if (lrd_q)
              lrd_q <= 1'b0;
            else
            begin
              in_rpc_q <= 1'b0;
              state_q  <= srp_pkg::SRP_IDLE;
            end
          end
        srp_pkg::SRP_DISCARD:
          state_q <= srp_pkg::SRP_DISCARD;
        default:
          state_q <= srp_pkg::SRP_IDLE;
      endcase
    end
  end

  // ============================================================
  // address pointer
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ptr_q <= 16'h0000;
    else if (state_q == srp_pkg::SRP_ADDR_HI && byte_ok)
      ptr_q <= {byte_b, lo_q};
    else if (xfer_last && hdr_q[`SRP_BIT_INC])
      ptr_q <= ptr_q + {12'h000, len_q} + 16'h0001;
    else if (state_q == srp_pkg::SRP_LWRITE && take)
    begin
      case (hdr_q)
        `SRP_W_ADDRL:  ptr_q <= {ptr_q[15:8], in_b};
        `SRP_W_ADDRH:  ptr_q <= {in_b, ptr_q[7:0]};
        `SRP_W_ADDADD: ptr_q <= ptr_q + {8'h00, in_b};
        default:       ptr_q <= ptr_q;
      endcase
    end
  end

  // ============================================================
  // memories; contents are not reset, software loads them
  always_ff @(posedge clock)
  begin
    if (wr_strobe && in_space)
    begin
      if (tbl_q)
        tmem[acc_addr[8:0]] <= byte_b;
      else
        dmem[acc_addr[7:0]] <= byte_b;
    end
  end

  // ============================================================
  // local control registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crc_en_q  <= 1'b1;
      cerr_q    <= 8'h00;
      tbl_q     <= 1'b0;
      timeout_q <= `SRP_TMO_RESET;
      led_q     <= 8'h00;
      uid_q     <= `SRP_UID_RESET;
      prst_q    <= 1'b0;
    end
    else
    begin
      prst_q <= 1'b0;
      if (crc_bad)
        cerr_q <= cerr_q + 8'h01;
      if (state_q == srp_pkg::SRP_LWRITE && take)
      begin
        case (hdr_q)
          `SRP_W_CRCEN:   crc_en_q  <= (in_b != 8'h00);
          `SRP_W_CRCCNT:  cerr_q    <= in_b;
          `SRP_W_TBLFLAG: tbl_q     <= (in_b != 8'h00);
          `SRP_W_TMO:     timeout_q <= in_b;
          `SRP_W_LED:     led_q     <= in_b;
          `SRP_W_UID:     uid_q     <= in_b;
          `SRP_W_PRST:    prst_q    <= (in_b == `SRP_PRST_KEY);
          default:        prst_q    <= 1'b0;
        endcase
      end
    end
  end

  // ============================================================
  // error status; a new event wins over a clearing write
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      stat_q <= 8'h00;
    else
      stat_q <= ((state_q == srp_pkg::SRP_LWRITE && take && hdr_q == `SRP_W_STAT)
                 ? (in_b & `SRP_ST_MASK) : stat_q)
                // a quiet idle parser holds no half command, so that gap is no error
                | ({7'h00, tmo && state_q != srp_pkg::SRP_DISCARD
                    && state_q != srp_pkg::SRP_IDLE} << `SRP_ST_TMO)
                | ({7'h00, wr_strobe && !in_space} << `SRP_ST_WPROT)
                | ({7'h00, rx_valid && pend_v_q && !take} << `SRP_ST_OVF)
                | ({7'h00, wdog_bite} << `SRP_ST_WDOG)
                | ({7'h00, crc_bad} << `SRP_ST_CRC);
  end

  // ============================================================
  // running crcs for the command frame and the answer
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crc_in_q  <= 8'h00;
      crc_out_q <= 8'h00;
    end
    else
    begin
      if (take)
        crc_in_q <= crc8((state_q == srp_pkg::SRP_IDLE) ? 8'h00 : crc_in_q, in_b);
      // an answer with no data leaves 00 as its crc
      if (state_q == srp_pkg::SRP_IDLE && take)
        crc_out_q <= 8'h00;
      else if (push_v && !(state_q == srp_pkg::SRP_RESP && !lrd_q))
        crc_out_q <= crc8(crc_out_q, push_b);
    end
  end

  // ============================================================
  // character gap timer in tenths of a character
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      gap_q <= 9'h000;
    else if (rx_valid)
      gap_q <= 9'h000;
    else if (tenth_tick && gap_q != 9'h1ff)
      gap_q <= gap_q + 9'h001;
  end

  // ============================================================
  // one held byte covers the host crc arriving while reads drain
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q   <= 8'h00;
      pend_v_q <= 1'b0;
    end
    else if (pend_v_q)
    begin
      if (take)
      begin
        pend_v_q <= rx_valid;
        pend_q   <= rx_data;
      end
    end
    else if (rx_valid && !rx_wants)
    begin
      pend_v_q <= 1'b1;
      pend_q   <= rx_data;
    end
  end

  // ============================================================
  // two-entry answer buffer; head feeds the port, spare absorbs a stall
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_q    <= 8'h00;
      head_v_q  <= 1'b0;
      spare_q   <= 8'h00;
      spare_v_q <= 1'b0;
    end
    else if (!head_v_q || tx_ready)
    begin
      if (spare_v_q)
      begin
        head_q    <= spare_q;
        head_v_q  <= 1'b1;
        spare_v_q <= 1'b0;
      end
      else
      begin
        // keep the last byte when nothing is pushed, so the port never shows unread memory
        head_q   <= push_v ? push_b : head_q;
        head_v_q <= push_v;
      end
    end
    else if (push_v)
    begin
      spare_q   <= push_b;
      spare_v_q <= 1'b1;
    end
  end

  assign tx_valid     = head_v_q;
  assign tx_data      = head_q;
  assign led_out      = led_q;
  assign unit_id_out  = uid_q;
  assign proc_reset   = prst_q;
  assign error_status = stat_q;

endmodule

`default_nettype wire

// *** srp_parser_chk.sv ***
// checker: port assertions for srp_parser.
// assumes a bind onto the parser instance.
`timescale 1ns/1ps
`default_nettype none
module srp_parser_chk (
  // clock and link
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       rx_valid,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  // side signals
  input wire logic       wdog_bite,
  input wire logic [7:0] led_out,
  input wire logic [7:0] unit_id_out,
  input wire logic       proc_reset,
  input wire logic [7:0] error_status
);
  logic [3:0] idle_q; // cycles without link traffic
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // saturating quiet count, so a late answer shows up
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) idle_q <= 4'h0;
    else if (rx_valid || tx_valid) idle_q <= 4'h0;
    else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
  sequence stall_s; tx_valid && !tx_ready; endsequence
  sequence quiet_s; !rx_valid [*4] ##0 error_status[3]; endsequence
  a_tx_hold: assert property (stall_s |=> tx_valid)
    else $error("answer dropped in stall");
  a_tx_data_hold: assert property (stall_s |=> $stable(tx_data))
    else $error("answer changed in stall");
  a_prst_pulse: assert property (proc_reset |=> !proc_reset)
    else $error("reset pulse too long");
  a_stat_reserved: assert property ((error_status & 8'h86) == 8'h00)
    else $error("reserved status bit set");
  a_wdog_flag: assert property (wdog_bite |=> error_status[3])
    else $error("watchdog flag missing");
  a_flag_sticky: assert property (quiet_s |=> error_status[3])
    else $error("flag cleared without write");
  a_answer_cause: assert property ($rose(tx_valid) |-> idle_q < 4'h8)
    else $error("answer without request");
  a_side_cause: assert property ($changed(led_out) || $changed(unit_id_out) |-> idle_q < 4'h4)
    else $error("side output changed idle");
endmodule
`default_nettype wire

// *** srp_host.sv ***
// host master model: frames commands with crc, collects answers.
// assumes the parser byte link on one clock.
`timescale 1ns/1ps
`default_nettype none
module srp_host (
  // clock
  input wire logic       clock,
  // byte link
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  input wire logic       tx_valid,
  output logic           tx_ready,
  input wire logic [7:0] tx_data
);
  logic [7:0] crc_q;    // running frame crc
  logic [7:0] ans_q[$]; // answer bytes taken
  logic       slow;     // stall every other cycle
  // one-wire crc8, reflected form
  function automatic logic [7:0] upd(logic [7:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
    crc_q = 8'h00;
  end
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clock) if (tx_valid === 1'b1 && tx_ready) ans_q.push_back(tx_data);
  // one byte then an idle cycle; a released line shows the inverse
  task put(input logic [7:0] b);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data = b;
    crc_q = upd(crc_q, b);
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
  // frame plus crc, then n bytes and crc; r[n] is the crc residue
  task cmd(input logic [7:0] q[$], input int n, output logic [7:0] r[$]);
    logic [7:0] a;
    a = 8'h00;
    crc_q = 8'h00;
    foreach (q[i]) put(q[i]);
    put(crc_q);
    for (int k = 0; k < 400 && ans_q.size() < n + 1; k++) @(posedge clock);
    r = ans_q;
    ans_q.delete();
    for (int i = 0; i < n && i < r.size(); i++) a = upd(a, r[i]);
    if (r.size() > n) r[n] = r[n] ^ a;
  endtask
endmodule
`default_nettype wire

// *** test_serial_remote_command_parser.sv ***
// testbench: command sequences against the parser with a host model.
// assumes srp_defs.svh and the host and checker files compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_serial_remote_command_parser;
  logic clock, reset_n, rx_valid, tenth_tick, wdog_bite, tx_valid, tx_ready, proc_reset;
  logic [7:0] rx_data, tx_data, led_out, unit_id_out, error_status, r[$], ex[$];
  logic [15:0] lc[11] = '{16'hdf5a, 16'hdc08, 16'hdd00, 16'hde02, 16'hda01,
                          16'hc000, 16'hc201, 16'hc300, 16'hca00, 16'hcbff, 16'hd04e};
  int num_errors = 0, checked = 0, cyc = 0, pulses = 0;
  srp_parser u_dut (.clock, .reset_n, .rx_valid, .rx_data, .tenth_tick, .wdog_bite, .tx_valid,
                    .tx_ready, .tx_data, .led_out, .unit_id_out, .proc_reset, .error_status);
  srp_host u_host (.clock, .rx_valid, .rx_data, .tx_valid, .tx_ready, .tx_data);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // tick every 4 cycles; cycle ceiling cuts a hang
  always @(negedge clock) tenth_tick <= (cyc % 4 == 0);
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (proc_reset === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin num_errors++; give_verdict(); end
  end
  task give_verdict();
    $display("counts: %0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rd(input logic [7:0] c, input logic [7:0] e);
    u_host.cmd('{c}, 1, r);
    `CHK("local read", e, r[0])
    `CHK("read crc", 8'h00, r[1])
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    u_host.cmd('{c, d}, 0, r);
    `CHK("write crc", 8'h00, r[0])
  endtask
  task rdq(input logic [7:0] q[$]);
    u_host.cmd(q, ex.size() - 1, r);
    foreach (ex[i]) `CHK("data", ex[i], r[i])
  endtask
  initial
  begin
    reset_n = 1'b0; wdog_bite = 1'b0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    foreach (lc[i]) rd(lc[i][15:8], lc[i][7:0]);
    $display("local reads done");
    wr(8'heb, 8'h05); rd(8'hcb, 8'h05);
    wr(8'he3, 8'h07); rd(8'hc3, 8'h07); wr(8'he3, 8'h00);
    wr(8'hf7, 8'h3c); `CHK("leds", 8'h3c, led_out)
    wr(8'hfd, 8'h42); rd(8'hdb, 8'h42);
    `CHK("unit id", 8'h42, unit_id_out)
    wr(8'hf8, 8'h20); wr(8'hf9, 8'h01); wr(8'hfa, 8'h10); rd(8'hd8, 8'h30); rd(8'hd9, 8'h01);
    $display("local writes done");
    ex = '{8'h00, 8'h00}; rdq('{8'h40});
    u_host.cmd('{8'h6e, 8'h10, 8'h00, 8'haa, 8'hbb, 8'hcc, 8'hdd}, 0, r); rd(8'hd8, 8'h14);
    u_host.cmd('{8'h61, 8'hee, 8'hff}, 0, r); rd(8'hd8, 8'h14);
    u_host.slow = 1'b1; ex = '{8'hcc, 8'hdd, 8'hee, 8'hff, 8'h00};
    rdq('{8'h46, 8'h12, 8'h00}); u_host.slow = 1'b0; rd(8'hd8, 8'h12);
    $display("data commands done");
    wr(8'hea, 8'h01);
    u_host.cmd('{8'h67, 8'h28, 8'h00, 8'h65, 8'h10, 8'h00, 8'h45, 8'h12, 8'h00, 8'h00, 8'h00}, 0, r);
    wr(8'hea, 8'h00); ex = '{8'hcc, 8'hdd, 8'h00};
    rdq('{8'h85, 8'h55, 8'h66});
    ex = '{8'h55, 8'h66, 8'h00}; rdq('{8'h45, 8'h10, 8'h00});
    $display("stored lists done");
    @(negedge clock) wdog_bite = 1'b1;
    @(negedge clock) wdog_bite = 1'b0;
    rd(8'hc1, 8'h08); wr(8'he1, 8'h00); `CHK("status", 8'h00, error_status)
    u_host.put(8'h44); repeat (40) @(negedge clock); rd(8'hc1, 8'h40); wr(8'he1, 8'h00);
    u_host.put(8'hc4); u_host.put(8'h00); repeat (60) @(negedge clock);
    `CHK("no answer", 0, u_host.ans_q.size()) rd(8'hc1, 8'h00);
    u_host.put(8'hff); rd(8'hdf, 8'h5a);
    wr(8'hfe, 8'h11); wr(8'hfe, 8'h5a); repeat (4) @(negedge clock); `CHK("resets", 1, pulses)
    $display("status and resets done");
    give_verdict();
  end
endmodule
bind srp_parser srp_parser_chk u_chk (.clock, .reset_n, .rx_valid, .tx_valid, .tx_ready, .tx_data,
  .wdog_bite, .led_out, .unit_id_out, .proc_reset, .error_status);
`default_nettype wire
